/* logic/hxb_bus_cycle.sv */
// One read or write cycle on the device's 16-bit non-multiplexed CPU bus
module hxb_bus_cycle #(
  parameter int STROBE_CYCLES = hxb_pkg::BUS_STROBE_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire logic we_in,
  input wire logic das_in,
  input wire logic [14:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] rdata_out,
  output logic [14:0] cpu_a_out,
  output logic [15:0] cpu_d_out,
  input wire logic [15:0] cpu_d_in,
  output logic cpu_d_oe_n_out,
  output logic cpu_cs_n_out,
  output logic cpu_rd_n_out,
  output logic cpu_wr_n_out,
  output logic cpu_das_out
);
  import hxb_pkg::*;

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} hxb_eng_type;
  hxb_eng_type state; // Cycle phase
  logic [7:0] cnt; // Strobe length counter
  logic we; // Held direction

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing: setup, strobe, hold, then a done pulse
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= E_IDLE;
      cnt <= 8'h00;
      done_out <= 1'b0;
      we <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state)
        E_IDLE: begin
          if (start_in) begin
            we <= we_in;
            state <= E_SETUP;
          end
        end
        E_SETUP: begin
          cnt <= 8'(STROBE_CYCLES - 1);
          state <= E_STROBE;
        end
        E_STROBE: begin
          // Hold strobe for the full access time
          if (cnt == 8'h00) begin
            state <= E_HOLD;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        E_HOLD: begin
          done_out <= 1'b1;
          state <= E_IDLE;
        end
        default: state <= E_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; address, select and data stay put for the whole cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cpu_a_out <= 15'h0000;
      cpu_d_out <= 16'h0000;
      cpu_d_oe_n_out <= 1'b1;
      cpu_cs_n_out <= 1'b1;
      cpu_rd_n_out <= 1'b1;
      cpu_wr_n_out <= 1'b1;
      cpu_das_out <= 1'b0;
      rdata_out <= 16'h0000;
    end else begin
      if (state == E_IDLE && start_in) begin
        cpu_a_out <= addr_in;
        cpu_d_out <= wdata_in;
        cpu_d_oe_n_out <= ~we_in;
        cpu_cs_n_out <= 1'b0;
        cpu_das_out <= das_in;
      end
      // Strobe goes low once address is settled
      if (state == E_SETUP) begin
        cpu_rd_n_out <= we;
        cpu_wr_n_out <= ~we;
      end
      if (state == E_STROBE && cnt == 8'h00) begin
        cpu_rd_n_out <= 1'b1;
        cpu_wr_n_out <= 1'b1;
        if (!we) begin
          rdata_out <= cpu_d_in;
        end
      end
      // Release the bus at the end of hold
      if (state == E_HOLD) begin
        cpu_cs_n_out <= 1'b1;
        cpu_d_oe_n_out <= 1'b1;
        cpu_das_out <= 1'b0;
      end
    end
  end

  assign busy_out = (state != E_IDLE);
endmodule : hxb_bus_cycle

/* logic/hxb_host_bridge.sv */
// Host controller driving the device's extended access words over its CPU bus
//
// Register access over AXI4-Lite is this design's own decision.
module hxb_host_bridge #(
  parameter int RESET_CYCLES = hxb_pkg::RESET_CYCLES,
  parameter int STROBE_CYCLES = hxb_pkg::BUS_STROBE_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  input wire logic [7:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  output logic [14:0] cpu_a_out,
  output logic [15:0] cpu_d_out,
  input wire logic [15:0] cpu_d_in,
  output logic cpu_d_oe_n_out,
  output logic cpu_cs_n_out,
  output logic cpu_rd_n_out,
  output logic cpu_wr_n_out,
  output logic cpu_das_out,
  output logic dev_reset_n_out
);
  import hxb_pkg::*;

  localparam int RW = $clog2(RESET_CYCLES + 1);

  typedef enum logic [3:0] {
    S_IDLE, S_HI, S_LO, S_DATA, S_CTRL, S_POLL, S_RDDATA, S_DIRECT, S_PARITY
  } hxb_state_type;

  hxb_state_type state; // Access sequencer
  hxb_op_type op; // Latched access kind
  logic [32:1] addr_reg; // Software address register
  logic [32:1] cmd_addr; // Address latched at command start
  logic [15:0] wdata_reg; // Software write data
  logic [15:0] rdata; // Last fetched word
  logic [1:0] rd_parity; // Parity of last fetched word
  logic [1:0] cmd_stb; // Latched strobes
  logic [1:0] cmd_par; // Latched parity for writes
  logic [6:0] burst; // Prefetch length
  logic done_flag; // Sticky completion
  logic refused_flag; // Sticky refused command
  logic [RW-1:0] rst_cnt; // Reset pin low counter
  logic [12:0] hi_cache; // Last upper address written
  logic [15:0] lo_cache; // Last lower address written
  logic [15:0] data_cache; // Last data word written
  logic hi_ok, lo_ok, data_ok; // Cache entries valid
  logic aw_full, w_full; // AXI write halves held
  logic [7:0] aw_addr; // Held write address
  logic [31:0] w_data; // Held write data
  logic [3:0] w_strb; // Held byte strobes
  logic wr_go; // Register write this cycle
  logic cmd_go; // Command accepted
  logic busy; // Access under way
  logic eng_start, eng_busy, eng_done; // Cycle engine handshake
  logic eng_we, eng_das; // Cycle kind
  logic [14:0] eng_addr; // Cycle word address
  logic [15:0] eng_wdata; // Cycle write word
  logic [15:0] eng_rdata; // Cycle read word
  logic need_hi, need_lo, need_data; // Words that must be rewritten
  logic indirect; // Current op is indirect

  ////////////////////////////////////////////////////////////////////////////
  // AXI write path: address and data taken in either order
  assign axi_awready_out = !aw_full && !axi_bvalid_out;
  assign axi_wready_out = !w_full && !axi_bvalid_out;
  assign wr_go = aw_full && w_full && !axi_bvalid_out;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      axi_bvalid_out <= 1'b0;
      axi_bresp_out <= 2'h0;
    end else begin
      if (axi_awvalid_in && axi_awready_out) begin
        aw_full <= 1'b1;
        aw_addr <= axi_awaddr_in;
      end
      if (axi_wvalid_in && axi_wready_out) begin
        w_full <= 1'b1;
        w_data <= axi_wdata_in;
        w_strb <= axi_wstrb_in;
      end
      // Answer once both halves are in; unmapped gives SLVERR
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        axi_bvalid_out <= 1'b1;
        axi_bresp_out <= (aw_addr > REG_CONFIG || aw_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (axi_bready_in) begin
        axi_bvalid_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read path with one-cycle answer
  assign axi_arready_out = !axi_rvalid_out;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      axi_rvalid_out <= 1'b0;
      axi_rdata_out <= 32'h0000_0000;
      axi_rresp_out <= 2'h0;
    end else if (axi_arvalid_in && axi_arready_out) begin
      axi_rvalid_out <= 1'b1;
      axi_rresp_out <= 2'h0;
      case (axi_araddr_in)
        REG_CMD: axi_rdata_out <= {24'h0, cmd_par, cmd_stb, 2'h0, op};
        REG_ADDR: axi_rdata_out <= addr_reg;
        REG_WDATA: axi_rdata_out <= {16'h0000, wdata_reg};
        REG_RDATA: axi_rdata_out <= {14'h0000, rd_parity, rdata};
        REG_STATUS: axi_rdata_out <= {28'h0, !dev_reset_n_out, refused_flag, done_flag, busy};
        REG_CONFIG: axi_rdata_out <= {25'h0, burst};
        default: begin
          axi_rdata_out <= 32'h0000_0000;
          axi_rresp_out <= 2'h2;
        end
      endcase
    end else if (axi_rready_in) begin
      axi_rvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; a command write while busy is refused
  assign busy = (state != S_IDLE);
  assign cmd_go = wr_go && aw_addr == REG_CMD && w_strb[0] && !busy && dev_reset_n_out;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      addr_reg <= 32'h0000_0000;
      wdata_reg <= 16'h0000;
      burst <= CFG_BURST_RESET;
      refused_flag <= 1'b0;
    end else if (wr_go) begin
      if (aw_addr == REG_ADDR) begin
        for (int i = 0; i < 4; i++) begin
          if (w_strb[i]) addr_reg[i*8+1 +: 8] <= w_data[i*8 +: 8];
        end
      end
      if (aw_addr == REG_WDATA) begin
        if (w_strb[0]) wdata_reg[7:0] <= w_data[7:0];
        if (w_strb[1]) wdata_reg[15:8] <= w_data[15:8];
      end
      if (aw_addr == REG_CONFIG && w_strb[0]) begin
        burst <= w_data[6:0];
      end
      // Refused flag: new refusal wins over write-one-to-clear
      if (aw_addr == REG_CMD && w_strb[0] && !cmd_go) begin
        refused_flag <= 1'b1;
      end else if (aw_addr == REG_STATUS && w_data[ST_REFUSED]) begin
        refused_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device reset pin: low for the full time after reset or on a request made while not busy
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rst_cnt <= RW'(RESET_CYCLES);
    end else if (wr_go && aw_addr == REG_CONFIG && w_strb[1] && w_data[CFG_RST_BIT] && !busy) begin
      rst_cnt <= RW'(RESET_CYCLES);
    end else if (rst_cnt != '0) begin
      rst_cnt <= rst_cnt - RW'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dev_reset_n_out <= 1'b0;
    end else begin
      dev_reset_n_out <= (rst_cnt == '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Skip decisions for words the device already holds
  assign indirect = (op == OP_IND_WR || op == OP_IND_RD);
  assign need_hi = !hi_ok || hi_cache != cmd_addr[32:20];
  assign need_lo = !lo_ok || lo_cache != cmd_addr[19:4];
  assign need_data = !data_ok || data_cache != wdata_reg;

  // State that follows the lower address word
  function automatic hxb_state_type after_lo(input hxb_op_type o, input logic nd);
    after_lo = S_CTRL;
    if (o == OP_IND_WR && nd) after_lo = S_DATA;
    if (o == OP_DIR_RD) after_lo = S_DIRECT;
  endfunction : after_lo

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= S_IDLE;
      op <= OP_IND_WR;
      cmd_addr <= 32'h0000_0000;
      cmd_stb <= 2'h0;
      cmd_par <= 2'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (cmd_go) begin
            op <= hxb_op_type'(w_data[1:0]);
            cmd_addr <= addr_reg;
            cmd_stb <= w_data[CMD_STB_LSB +: 2];
            cmd_par <= w_data[CMD_PAR_LSB +: 2];
            state <= S_HI;
          end
        end
        S_HI: begin
          if (!need_hi) state <= S_LO;
          else if (eng_done) state <= S_LO;
        end
        S_LO: begin
          if (!need_lo || eng_done) state <= after_lo(op, need_data);
        end
        S_DATA: if (eng_done) state <= S_CTRL;
        S_CTRL: begin
          if (eng_done) state <= indirect ? S_POLL : S_DIRECT;
        end
        S_POLL: begin
          // Keep polling until hardware clears the request
          if (eng_done && !eng_rdata[CTRL_REQ_BIT]) begin
            state <= (op == OP_IND_RD) ? S_RDDATA : S_IDLE;
          end
        end
        S_RDDATA: if (eng_done) state <= S_IDLE;
        S_DIRECT: if (eng_done) state <= (op == OP_DIR_RD) ? S_PARITY : S_IDLE;
        S_PARITY: if (eng_done) state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cache of device address and data words
  always_ff @(posedge clk_in) begin
    if (reset_in || !dev_reset_n_out) begin
      hi_ok <= 1'b0;
      lo_ok <= 1'b0;
      data_ok <= 1'b0;
      hi_cache <= 13'h0000;
      lo_cache <= 16'h0000;
      data_cache <= 16'h0000;
    end else if (eng_done) begin
      if (state == S_HI) begin
        hi_ok <= 1'b1;
        hi_cache <= cmd_addr[32:20];
      end
      if (state == S_LO) begin
        lo_ok <= 1'b1;
        lo_cache <= cmd_addr[19:4];
      end
      if (state == S_DATA) begin
        data_ok <= 1'b1;
        data_cache <= wdata_reg;
      end
      // An indirect read overwrites the device data word
      if (state == S_CTRL && op == OP_IND_RD) data_ok <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetched data, parity and completion flag
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata <= 16'h0000;
      rd_parity <= 2'h0;
      done_flag <= 1'b0;
    end else begin
      if (eng_done && (state == S_RDDATA || (state == S_DIRECT && op == OP_DIR_RD))) begin
        rdata <= eng_rdata;
      end
      if (eng_done && (state == S_PARITY || (state == S_POLL && op == OP_IND_RD))) begin
        rd_parity <= eng_rdata[CTRL_PAR_LSB +: 2];
      end
      // Completion wins over write-one-to-clear
      if (busy && !next_busy()) done_flag <= 1'b1;
      else if (wr_go && aw_addr == REG_STATUS && w_data[ST_DONE]) done_flag <= 1'b0;
    end
  end

  // True while the sequencer stays busy after this edge
  function automatic logic next_busy();
    next_busy = 1'b1;
    if (eng_done && (state == S_RDDATA || state == S_PARITY)) next_busy = 1'b0;
    if (eng_done && state == S_POLL && !eng_rdata[CTRL_REQ_BIT] && op == OP_IND_WR) next_busy = 1'b0;
    if (eng_done && state == S_DIRECT && op == OP_DIR_WR) next_busy = 1'b0;
  endfunction : next_busy

  ////////////////////////////////////////////////////////////////////////////
  // Cycle request for the current state
  always_comb begin
    eng_we = 1'b1;
    eng_das = 1'b0;
    eng_addr = 15'(DEV_CTRL >> 1);
    eng_wdata = 16'h0000;
    case (state)
      S_HI: begin
        eng_addr = 15'(DEV_HI >> 1);
        eng_wdata = {3'h0, cmd_addr[32:20]};
      end
      S_LO: begin
        eng_addr = 15'(DEV_LO >> 1);
        eng_wdata = cmd_addr[19:4];
      end
      S_DATA: begin
        eng_addr = 15'(DEV_DATA >> 1);
        eng_wdata = wdata_reg;
      end
      S_CTRL: begin
        // Request only for indirect; strobes 00 for indirect reads
        eng_wdata[CTRL_BURST_LSB +: 7] = burst;
        eng_wdata[CTRL_REQ_BIT] = indirect;
        eng_wdata[CTRL_A31_LSB +: 3] = cmd_addr[3:1];
        eng_wdata[CTRL_STB_LSB +: 2] = (op == OP_IND_RD) ? STB_READ : cmd_stb;
        eng_wdata[CTRL_PAR_LSB +: 2] = cmd_par;
      end
      S_POLL, S_PARITY: eng_we = 1'b0;
      S_RDDATA: begin
        eng_we = 1'b0;
        eng_addr = 15'(DEV_DATA >> 1);
      end
      S_DIRECT: begin
        eng_we = (op == OP_DIR_WR);
        eng_das = 1'b1;
        eng_addr = cmd_addr[15:1];
        eng_wdata = wdata_reg;
      end
      default: eng_we = 1'b1;
    endcase
  end

  assign eng_start = busy && !eng_busy && !eng_done
    && !(state == S_HI && !need_hi) && !(state == S_LO && !need_lo);

  hxb_bus_cycle #(.STROBE_CYCLES(STROBE_CYCLES)) u_cycle (
    .clk_in(clk_in), .reset_in(reset_in),
    .start_in(eng_start), .we_in(eng_we), .das_in(eng_das),
    .addr_in(eng_addr), .wdata_in(eng_wdata),
    .busy_out(eng_busy), .done_out(eng_done), .rdata_out(eng_rdata),
    .cpu_a_out(cpu_a_out), .cpu_d_out(cpu_d_out), .cpu_d_in(cpu_d_in),
    .cpu_d_oe_n_out(cpu_d_oe_n_out), .cpu_cs_n_out(cpu_cs_n_out),
    .cpu_rd_n_out(cpu_rd_n_out), .cpu_wr_n_out(cpu_wr_n_out),
    .cpu_das_out(cpu_das_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [RW:0] low_len; // Cycles the reset pin has been low
  always_ff @(posedge clk_in) begin
    if (reset_in || dev_reset_n_out) low_len <= '0;
    else low_len <= low_len + (RW+1)'(1);
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_das_indirect;
    !cpu_cs_n_out && state != S_DIRECT && state != S_IDLE |-> !cpu_das_out;
  endproperty
  a_das_indirect: assert property (p_das_indirect) else $error("select high in indirect cycle");
  property p_das_direct;
    eng_start && state == S_DIRECT |=> ##1 cpu_das_out && !cpu_cs_n_out;
  endproperty
  a_das_direct: assert property (p_das_direct) else $error("select low in direct cycle");
  property p_ctrl_req;
    eng_start && state == S_CTRL && indirect |=> cpu_d_out[CTRL_REQ_BIT] && !cpu_d_oe_n_out;
  endproperty
  a_ctrl_req: assert property (p_ctrl_req) else $error("request bit not written");
  property p_rd_stb;
    eng_start && state == S_CTRL && op == OP_IND_RD |=> cpu_d_out[13:12] == 2'h0;
  endproperty
  a_rd_stb: assert property (p_rd_stb) else $error("read strobes not zero");
  property p_poll;
    eng_done && state == S_CTRL && indirect |=> state == S_POLL ##1 !cpu_cs_n_out[*2];
  endproperty
  a_poll: assert property (p_poll) else $error("no poll after request");
  property p_rd_after;
    eng_done && state == S_POLL && eng_rdata[8] |=> state == S_POLL;
  endproperty
  a_rd_after: assert property (p_rd_after) else $error("data read before clear");
  property p_reset_len;
    $rose(dev_reset_n_out) |-> low_len >= (RW+1)'(RESET_CYCLES);
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("reset pin pulse too short");
  property p_dir_wr;
    eng_done && state == S_CTRL && op == OP_DIR_WR |=> state == S_DIRECT ##[1:3] cpu_das_out;
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("direct write without strobes");
  property p_refuse;
    wr_go && aw_addr == REG_CMD && w_strb[0] && busy |=> $stable(op) && $stable(cmd_addr) && refused_flag;
  endproperty
  a_refuse: assert property (p_refuse) else $error("command taken while busy");
  property p_parity;
    eng_done && state == S_PARITY |=> rd_parity == $past(eng_rdata[15:14]);
  endproperty
  a_parity: assert property (p_parity) else $error("parity not captured");
  c_ind_rd: cover property (state == S_RDDATA && eng_done);
  c_dir_wr: cover property (state == S_DIRECT && op == OP_DIR_WR && eng_done);
  c_repoll: cover property (eng_done && state == S_POLL && eng_rdata[8]);
endmodule : hxb_host_bridge

/* logic/hxb_pkg.sv */
// Constants shared by the host extended access bridge files
package hxb_pkg;
  // Device word offsets, as byte addresses on the device's CPU bus
  localparam logic [15:0] DEV_CTRL = 16'h0000;
  localparam logic [15:0] DEV_DATA = 16'h0004;
  localparam logic [15:0] DEV_HI = 16'h0008;
  localparam logic [15:0] DEV_LO = 16'h000A;
  // Device control word fields
  localparam int CTRL_BURST_LSB = 0;
  localparam int CTRL_REQ_BIT = 8;
  localparam int CTRL_A31_LSB = 9;
  localparam int CTRL_STB_LSB = 12;
  localparam int CTRL_PAR_LSB = 14;
  localparam logic [1:0] STB_READ = 2'h0;
  // Own AXI register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CONFIG = 8'h14;
  // Own register fields
  localparam int CMD_STB_LSB = 4;
  localparam int CMD_PAR_LSB = 6;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_RESET = 3;
  localparam int CFG_RST_BIT = 8;
  localparam logic [6:0] CFG_BURST_RESET = 7'h01;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_TIME_US = 1000;
  localparam int RESET_CYCLES = (RESET_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_STROBE_NS = 40;
  localparam int BUS_STROBE_CYCLES = (BUS_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Access kinds a command may ask for
  typedef enum logic [1:0] {
    OP_IND_WR, OP_IND_RD, OP_DIR_WR, OP_DIR_RD
  } hxb_op_type;
endpackage : hxb_pkg

/* verif/hxb_dev_model.sv */
// Behavioural model of the device's four extended access words and memory
module hxb_dev_model (
  input wire logic clk_in,
  input wire logic [14:0] cpu_a_in,
  input wire logic [15:0] cpu_d_in,
  input wire logic cpu_cs_n_in,
  input wire logic cpu_rd_n_in,
  input wire logic cpu_wr_n_in,
  input wire logic cpu_das_in,
  input wire logic cpu_d_oe_n_in,
  output logic [15:0] cpu_d_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ctl = 16'h0001, dat = 16'h0000, hi = 16'h0000, lo = 16'h0000, last = 16'h0000;
  logic [17:0] mem [int];
  int n = 0;
  // Word index: page plus bus offset directly, or hi, lo and the control word address bits indirectly
  function automatic int key(input logic [14:0] off, input logic dir);
    key = dir ? {hi[12:0], lo[15:12], off} : {hi[12:0], lo, ctl[11:9]};
  endfunction : key
  // Released bus shows the inverse of the last value
  assign cpu_d_out = (cpu_cs_n_in || cpu_rd_n_in) ? ~last : last;
  // Writes land as the write strobe rises
  always @(posedge cpu_wr_n_in) if (!cpu_cs_n_in && !cpu_d_oe_n_in) begin
    if (cpu_das_in) mem[key(cpu_a_in, 1'h1)] = {ctl[15:14], cpu_d_in};
    else case (cpu_a_in[2:0])
      3'h0: begin ctl = cpu_d_in & 16'hFF7F; n = 3; end
      3'h2: dat = cpu_d_in;
      3'h4: hi = cpu_d_in & 16'h1FFF;
      3'h5: lo = cpu_d_in;
      default: ;
    endcase
  end
  // Pending request completes a few clocks later
  always @(posedge clk_in) if (n > 0) begin
    n = n - 1;
    if (n == 0 && ctl[8]) begin
      if (ctl[13:12] == 2'h0) {ctl[15:14], dat} = mem[key(15'h0, 1'h0)];
      else mem[key(15'h0, 1'h0)] = {ctl[15:14], dat};
      ctl[8] = 1'h0;
    end
  end
  // Read data fetched as the read strobe falls
  always @(negedge cpu_rd_n_in) if (!cpu_cs_n_in) begin
    if (cpu_das_in) {ctl[15:14], last} = mem[key(cpu_a_in, 1'h1)];
    else last = cpu_a_in[2:0] == 3'h0 ? ctl : cpu_a_in[2:0] == 3'h2 ? dat : cpu_a_in[2] ? (cpu_a_in[0] ? lo : hi) : dat;
  end
endmodule : hxb_dev_model

/* verif/hxb_host_bridge_test.sv */
// Bench for the host bridge: AXI register tasks and access sequences
module hxb_host_bridge_test;
  timeunit 1ns;
  timeprecision 1ps;
  import hxb_pkg::*;
  logic clk_in = 1'h0, reset_in = 1'h1, axi_awvalid_in = 1'h0, axi_wvalid_in = 1'h0;
  logic axi_bready_in = 1'h0, axi_arvalid_in = 1'h0, axi_rready_in = 1'h0, axi_awready_out;
  logic axi_wready_out, axi_bvalid_out, axi_arready_out, axi_rvalid_out, cpu_d_oe_n_out;
  logic cpu_cs_n_out, cpu_rd_n_out, cpu_wr_n_out, cpu_das_out, dev_reset_n_out;
  logic [7:0] axi_awaddr_in = 8'h00, axi_araddr_in = 8'h00;
  logic [31:0] axi_wdata_in = 32'h0, axi_rdata_out, v;
  logic [3:0] axi_wstrb_in = 4'hF;
  logic [1:0] axi_bresp_out, axi_rresp_out, rr, br;
  logic [14:0] cpu_a_out;
  logic [15:0] cpu_d_out, cpu_d_in;
  int errors = 0, compares = 0;
  hxb_host_bridge #(.RESET_CYCLES(20)) DUT (.clk_in(clk_in), .reset_in(reset_in),
    .axi_awaddr_in(axi_awaddr_in), .axi_awvalid_in(axi_awvalid_in),
    .axi_awready_out(axi_awready_out), .axi_wdata_in(axi_wdata_in),
    .axi_wstrb_in(axi_wstrb_in), .axi_wvalid_in(axi_wvalid_in),
    .axi_wready_out(axi_wready_out), .axi_bresp_out(axi_bresp_out),
    .axi_bvalid_out(axi_bvalid_out), .axi_bready_in(axi_bready_in),
    .axi_araddr_in(axi_araddr_in), .axi_arvalid_in(axi_arvalid_in),
    .axi_arready_out(axi_arready_out), .axi_rdata_out(axi_rdata_out),
    .axi_rresp_out(axi_rresp_out), .axi_rvalid_out(axi_rvalid_out),
    .axi_rready_in(axi_rready_in), .cpu_a_out(cpu_a_out), .cpu_d_out(cpu_d_out),
    .cpu_d_in(cpu_d_in), .cpu_d_oe_n_out(cpu_d_oe_n_out), .cpu_cs_n_out(cpu_cs_n_out),
    .cpu_rd_n_out(cpu_rd_n_out), .cpu_wr_n_out(cpu_wr_n_out), .cpu_das_out(cpu_das_out),
    .dev_reset_n_out(dev_reset_n_out));
  hxb_dev_model dev (.clk_in(clk_in), .cpu_a_in(cpu_a_out), .cpu_d_in(cpu_d_out),
    .cpu_cs_n_in(cpu_cs_n_out), .cpu_rd_n_in(cpu_rd_n_out), .cpu_wr_n_in(cpu_wr_n_out),
    .cpu_das_in(cpu_das_out), .cpu_d_oe_n_in(cpu_d_oe_n_out), .cpu_d_out(cpu_d_in));
  initial forever #5 clk_in = ~clk_in;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk_in);
    {axi_awaddr_in, axi_wdata_in} <= {a, d};
    {axi_awvalid_in, axi_wvalid_in, axi_bready_in} <= 3'h7;
    do begin
      @(negedge clk_in);
      {ta, tw, tb, br} = {axi_awready_out, axi_wready_out, axi_bvalid_out, axi_bresp_out};
      @(posedge clk_in);
      if (ta) axi_awvalid_in <= 1'h0;
      if (tw) axi_wvalid_in <= 1'h0;
    end while (tb !== 1'h1);
    axi_bready_in <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    @(posedge clk_in);
    axi_araddr_in <= a;
    {axi_arvalid_in, axi_rready_in} <= 2'h3;
    do begin
      @(negedge clk_in);
      t = axi_arready_out;
      @(posedge clk_in);
    end while (t !== 1'h1);
    axi_arvalid_in <= 1'h0;
    do begin
      @(negedge clk_in);
      {t, d, r} = {axi_rvalid_out, axi_rdata_out, axi_rresp_out};
      @(posedge clk_in);
    end while (t !== 1'h1);
    axi_rready_in <= 1'h0;
  endtask : rd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Issue a command and poll until done, then clear done
  task automatic run(input logic [31:0] c);
    wr(REG_CMD, c);
    do rd(REG_STATUS, v, rr); while (v[ST_DONE] !== 1'h1);
    wr(REG_STATUS, 32'h6);
  endtask : run
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial begin
    repeat (30000) @(posedge clk_in);
    errors++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    reset_in <= 1'h0;
    rd(REG_STATUS, v, rr);
    chk("reset flag", 32'h8, v & 32'h8);
    repeat (30) @(posedge clk_in);
    wr(REG_ADDR, 32'h0ABCDE75);
    chk("write resp", 32'h0, {30'h0, br});
    wr(REG_WDATA, 32'hBEEF);
    run(32'hB0);
    run(32'h01);
    rd(REG_RDATA, v, rr);
    chk("indirect read", 32'h2BEEF, v);
    run(32'h03);
    rd(REG_RDATA, v, rr);
    chk("direct read", 32'h2BEEF, v);
    wr(REG_ADDR, 32'h0ABCD432);
    wr(REG_WDATA, 32'h1234);
    run(32'h72);
    run(32'h01);
    rd(REG_RDATA, v, rr);
    chk("direct write", 32'h11234, v);
    wr(REG_CONFIG, 32'h105);
    wr(REG_CMD, 32'h01);
    rd(REG_STATUS, v, rr);
    chk("reset request", 32'hC, v & 32'hC);
    rd(REG_CONFIG, v, rr);
    chk("burst length", 32'h5, v);
    repeat (30) @(posedge clk_in);
    wr(REG_ADDR, 32'h80);
    wr(REG_WDATA, 32'h2200);
    run(32'hB0);
    run(32'h01);
    rd(REG_RDATA, v, rr);
    chk("config word", 32'h22200, v);
    wr(REG_CMD, 32'h01);
    wr(REG_CMD, 32'h00);
    rd(REG_STATUS, v, rr);
    chk("refused flag", 32'h4, v & 32'h4);
    rd(8'h40, v, rr);
    chk("unmapped resp", 32'h2, {30'h0, rr});
    wr(8'h41, 32'h0);
    chk("misaligned resp", 32'h2, {30'h0, br});
    complete_run();
  end
endmodule : hxb_host_bridge_test
